// file: pkg/bstat_pkg.sv
package bstat_pkg;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_QMARK = 8'h3F;
    localparam logic [7:0] CH_CLR = 8'h63;
    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_C = 8'h43;
    localparam logic [7:0] CH_1 = 8'h31;
    localparam logic [7:0] SOC_MAX = 8'h64;
    localparam logic [3:0] LINE_MIN = 4'h8;
    localparam logic [3:0] LINE_MAX = 4'h9;
    localparam int STAT_N = 50;
    localparam logic [5:0] LAST_ID = 6'h31;
    localparam logic [63:0] PROTECT_MASK = 64'h0000_0000_0000_0080;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [3:0] {
        SG_TAG = 4'b0000, SG_ID = 4'b0001, SG_C1 = 4'b0010,
        SG_VAL = 4'b0011, SG_C2 = 4'b0100, SG_INF = 4'b0101,
        SG_C3 = 4'b0110, SG_TS = 4'b0111, SG_C4 = 4'b1000,
        SG_CK = 4'b1001, SG_LF = 4'b1010
    } seg_e;

    typedef enum logic [1:0] {ST_RX = 2'b00, ST_EMIT = 2'b01} mode_e;

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction : hex_char

    // {valid, nibble}; upper-case digits only, 'c' is a command
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        logic [7:0] d;
        d = 8'h00;
        if (c >= 8'h30 && c <= 8'h39) begin
            d = c - 8'h30;
            return {1'b1, d[3:0]};
        end
        if (c >= 8'h41 && c <= 8'h46) begin
            d = c - 8'h37;
            return {1'b1, d[3:0]};
        end
        return 5'h00;
    endfunction : hex_val

    function automatic logic id_valid(input logic [5:0] id);
        return (id <= 6'h27 && id != 6'h1A) || id == 6'h2D ||
               id == 6'h2E || id == LAST_ID;
    endfunction : id_valid

    // digits of the value, info and timestamp fields for one statistic
    function automatic logic [3:0] seg_len(input seg_e s,
                                           input logic [5:0] id);
        logic [3:0] v, i, t;
        v = 4'h8;
        i = 4'h8;
        t = 4'h8;
        if (id <= 6'h06) begin
            i = 4'h0;
            t = 4'h0;
        end else if (id == 6'h07) begin
            v = 4'h0;
            t = 4'h0;
        end else if (id <= 6'h09) begin
            v = 4'h4;
            i = 4'h0;
        end else if (id <= 6'h0B) begin
            v = 4'h2;
            i = 4'h4;
        end else if (id >= 6'h12) begin
            v = 4'h0;
        end
        if (!id_valid(id)) return 4'h0;
        case (s)
            SG_TAG: return 4'h4;
            SG_ID: return 4'h2;
            SG_VAL: return v;
            SG_INF: return i;
            SG_TS: return t;
            SG_CK: return 4'h2;
            default: return 4'h1;
        endcase
    endfunction : seg_len

    function automatic logic [3:0] nib_of(input logic [31:0] w,
                                          input logic [3:0] i);
        logic [31:0] s;
        s = w >> {i, 2'b00};
        return s[3:0];
    endfunction : nib_of
endpackage : bstat_pkg

// file: logic/bstat_parser.sv
module byte_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r, rd_r;
    logic [AW:0] cnt_r;
    logic push, pop;

    assign in_ready = cnt_r != (AW+1)'(DEPTH);
    assign push = in_valid && in_ready;
    // output stage is a register so the pins come from flops
    assign pop = cnt_r != '0 && (!out_valid || out_ready);

    always_ff @(posedge ref_clk) begin
        if (push) mem_r[wr_r] <= in_data;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wr_r <= wr_r + 1'b1;
            if (pop) rd_r <= rd_r + 1'b1;
            case ({push, pop})
                2'b10: cnt_r <= cnt_r + 1'b1;
                2'b01: cnt_r <= cnt_r - 1'b1;
                default: cnt_r <= cnt_r;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_data <= '0;
            out_valid <= 1'b0;
        end else if (pop) begin
            out_data <= mem_r[rd_r];
            out_valid <= 1'b1;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule : byte_fifo

module bstat_parser
    import bstat_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic stat_we,
    input wire logic [5:0] stat_id,
    input wire logic [31:0] stat_val,
    input wire logic [31:0] stat_inf,
    input wire logic [31:0] stat_ts,
    output logic [6:0] soc_level,
    output logic bad_sentence
);
    logic [7:0] line_r [9];
    logic [3:0] len_r;
    logic [7:0] rx_sum_r;
    logic [31:0] val_r [STAT_N];
    logic [31:0] inf_r [STAT_N];
    logic [31:0] ts_r [STAT_N];
    mode_e mode_r, mode_nxt;
    seg_e seg_r;
    logic [3:0] dig_r;
    logic [5:0] cur_id_r;
    logic all_r;
    logic [7:0] tx_sum_r;

    logic take, eol, p2, frame_ok, is_sc, is_ss;
    logic [7:0] ck_sum, par, pc;
    logic [4:0] h_hi, h_lo, ck_hi, ck_lo;
    logic par_ok, do_soc, do_all, do_one, do_clr, start;
    logic [3:0] len;
    logic [31:0] word;
    logic [7:0] ch;
    logic push, push_ok, seg_done, last_id;

    assign take = mode_r == ST_RX && rx_valid && rx_ready;
    assign eol = take && rx_data == CH_LF;

    always_comb begin
        p2 = len_r == LINE_MAX;
        ck_hi = hex_val(line_r[1]);
        ck_lo = hex_val(line_r[0]);
        ck_sum = rx_sum_r - line_r[0] - line_r[1];
        is_sc = (p2 ? line_r[8] : line_r[7]) == CH_S &&
                (p2 ? line_r[7] : line_r[6]) == CH_C &&
                (p2 ? line_r[6] : line_r[5]) == CH_1;
        is_ss = (p2 ? line_r[8] : line_r[7]) == CH_S &&
                (p2 ? line_r[7] : line_r[6]) == CH_S &&
                (p2 ? line_r[6] : line_r[5]) == CH_1;
        frame_ok = (len_r == LINE_MIN || p2) && ck_hi[4] && ck_lo[4] &&
                   {ck_hi[3:0], ck_lo[3:0]} == ck_sum &&
                   (p2 ? line_r[5] : line_r[4]) == CH_COMMA &&
                   line_r[2] == CH_COMMA;
        h_hi = p2 ? hex_val(line_r[4]) : 5'h10;
        h_lo = hex_val(line_r[3]);
        par_ok = h_hi[4] && h_lo[4];
        par = {h_hi[3:0], h_lo[3:0]};
        pc = line_r[3];
    end

    assign do_soc = eol && frame_ok && is_sc && par_ok &&
                    par <= SOC_MAX;
    assign do_all = eol && frame_ok && is_ss && !p2 &&
                    pc == CH_QMARK;
    assign do_clr = eol && frame_ok && is_ss && !p2 &&
                    pc == CH_CLR;
    assign do_one = eol && frame_ok && is_ss && par_ok &&
                    id_valid(par[5:0]) && par[7:6] == 2'b00;
    assign start = do_all || do_one;

    // line buffer keeps the nine newest characters; longer lines fail
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            len_r <= 4'h0;
            rx_sum_r <= 8'h00;
            for (int k = 0; k < 9; k++) line_r[k] <= 8'h00;
        end else if (eol) begin
            len_r <= 4'h0;
            rx_sum_r <= 8'h00;
        end else if (take && rx_data != CH_CR) begin
            if (len_r != 4'hF) len_r <= len_r + 4'h1;
            rx_sum_r <= rx_sum_r + rx_data;
            line_r[0] <= rx_data;
            for (int k = 1; k < 9; k++) line_r[k] <= line_r[k-1];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            soc_level <= 7'h00;
            bad_sentence <= 1'b0;
        end else begin
            if (do_soc) soc_level <= par[6:0];
            bad_sentence <= eol && !do_soc && !start && !do_clr;
        end
    end

    // an update in the clearing cycle wins over the clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int k = 0; k < STAT_N; k++) begin
                val_r[k] <= 32'h0000_0000;
                inf_r[k] <= 32'h0000_0000;
                ts_r[k] <= 32'h0000_0000;
            end
        end else begin
            for (int k = 0; k < STAT_N; k++) begin
                if (stat_we && stat_id == 6'(k)) begin
                    val_r[k] <= stat_val;
                    inf_r[k] <= stat_inf;
                    ts_r[k] <= stat_ts;
                end else if (do_clr && !PROTECT_MASK[k]) begin
                    val_r[k] <= 32'h0000_0000;
                    inf_r[k] <= 32'h0000_0000;
                    ts_r[k] <= 32'h0000_0000;
                end
            end
        end
    end

    always_comb begin
        len = seg_len(seg_r, cur_id_r);
        case (seg_r)
            SG_ID: word = {26'h0, cur_id_r};
            SG_VAL: word = val_r[cur_id_r];
            SG_INF: word = inf_r[cur_id_r];
            SG_TS: word = ts_r[cur_id_r];
            SG_CK: word = {24'h0, tx_sum_r};
            default: word = 32'h0000_0000;
        endcase
        case (seg_r)
            SG_TAG: ch = (dig_r == 4'h2) ? CH_1 :
                         (dig_r == 4'h3) ? CH_COMMA : CH_S;
            SG_ID, SG_VAL, SG_INF, SG_TS, SG_CK:
                ch = hex_char(nib_of(word, len - 4'h1 - dig_r));
            SG_LF: ch = CH_LF;
            default: ch = CH_COMMA;
        endcase
    end

    assign push = mode_r == ST_EMIT && len != 4'h0;
    assign seg_done = mode_r == ST_EMIT &&
                      (len == 4'h0 || (push_ok && dig_r == len - 4'h1));
    assign last_id = !all_r || cur_id_r == LAST_ID;

    always_comb begin
        mode_nxt = mode_r;
        if (start) mode_nxt = ST_EMIT;
        else if (seg_done && seg_r == SG_LF && last_id) mode_nxt = ST_RX;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= ST_RX;
            rx_ready <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            rx_ready <= mode_nxt == ST_RX;
        end
    end

    // one sentence per statistic; invalid ids pass with no characters
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            seg_r <= SG_TAG;
            dig_r <= 4'h0;
            cur_id_r <= 6'h00;
            all_r <= 1'b0;
            tx_sum_r <= 8'h00;
        end else if (start) begin
            seg_r <= SG_TAG;
            dig_r <= 4'h0;
            all_r <= do_all;
            cur_id_r <= do_all ? 6'h00 : par[5:0];
            tx_sum_r <= 8'h00;
        end else if (mode_r == ST_EMIT) begin
            if (push_ok && seg_r < SG_CK) tx_sum_r <= tx_sum_r + ch;
            if (seg_done) begin
                dig_r <= 4'h0;
                if (seg_r == SG_LF) begin
                    seg_r <= SG_TAG;
                    tx_sum_r <= 8'h00;
                    if (!last_id) cur_id_r <= cur_id_r + 6'h01;
                end else begin
                    seg_r <= seg_e'(seg_r + 4'h1);
                end
            end else if (push_ok) begin
                dig_r <= dig_r + 4'h1;
            end
        end
    end

    logic fifo_in_ready;
    assign push_ok = push && fifo_in_ready;

    byte_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .in_data(ch),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .out_data(tx_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready)
    );

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    soc_range_a: assert property (soc_level <= 7'h64)
        else $error("charge level above 100");
    soc_hold_a: assert property (eol && is_sc && par > SOC_MAX |=>
        $stable(soc_level)) else $error("bad charge level stored");
    clr_protect_a: assert property (do_clr && !stat_we |=>
        val_r[7] == $past(val_r[7])) else $error("protected cleared");
    clr_total_a: assert property (do_clr && !stat_we |=>
        val_r[0] == 32'h0 && ts_r[8] == 32'h0) else $error("not cleared");
    all_start_a: assert property (do_all |=>
        all_r && cur_id_r == 6'h00 && mode_r == ST_EMIT)
        else $error("all request not started at id 0");
    one_start_a: assert property (do_one |=> !all_r &&
        cur_id_r == $past(par[5:0])) else $error("wrong single id");
    tag_char_a: assert property (push && seg_r == SG_TAG &&
        dig_r == 4'h0 |-> ch == CH_S) else $error("tag not first");
    no_ts_a: assert property (mode_r == ST_EMIT && seg_r == SG_TS &&
        cur_id_r <= 6'h07 |-> !push) else $error("timestamp on total");
    id_hex_a: assert property (push && seg_r == SG_ID &&
        cur_id_r == 6'h0A |-> ch == (dig_r == 4'h0 ? 8'h30 : 8'h41))
        else $error("identifier digits wrong");
    skip_26_a: assert property (mode_r == ST_EMIT &&
        cur_id_r == 6'h1A |-> !push) else $error("id 26 emitted");
endmodule : bstat_parser

// file: tb/bstat_host.sv
module bstat_host (
    input wire logic ref_clk,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stall = 1'b1;
    logic hold = 1'b0;
    string got = "";
    int lfs = 0;

    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end

    function automatic string hx(input logic [31:0] v, input int n);
        string s;
        logic [3:0] d;
        s = "";
        for (int i = n - 1; i >= 0; i--) begin
            d = 4'(v >> (4 * i));
            s = {s, string'(d < 4'hA ? 8'h30 + d : 8'h37 + d)};
        end
        return s;
    endfunction : hx

    // byte sum of everything before the checksum digits
    function automatic string ck(input string s);
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < s.len(); i++) sum += s[i];
        return hx({24'h0, sum}, 2);
    endfunction : ck

    // each byte held until the parser shows ready at a rising edge
    task automatic raw(input string s);
        for (int i = 0; i < s.len(); i++) begin
            rx_data <= s[i];
            rx_valid <= 1'b1;
            @(posedge ref_clk);
            while (rx_ready !== 1'b1) @(posedge ref_clk);
        end
        rx_valid <= 1'b0;
        rx_data <= ~s[s.len() - 1];
    endtask : raw

    task automatic cmd(input string body);
        raw({body, ck(body), "\n"});
    endtask : cmd

    // a slow reader: every other cycle while stalled, every cycle once stall drops, not at all while held
    always @(posedge ref_clk) begin
        if (tx_valid === 1'b1 && tx_ready) begin
            got = {got, string'(tx_data)};
            if (tx_data == 8'h0A) lfs++;
        end
        tx_ready <= !hold && (stall ? !tx_ready : 1'b1);
    end
endmodule : bstat_host

// file: tb/test_battery_stats_command_parser.sv
module test_battery_stats_command_parser;
    import bstat_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] rx_data, tx_data;
    logic rx_valid, rx_ready, tx_valid, tx_ready, stat_we, bad_sentence;
    logic [5:0] stat_id = 6'h00;
    logic [31:0] stat_val = 32'h0, stat_inf = 32'h0, stat_ts = 32'h0;
    logic [6:0] soc_level;
    int fails = 0;
    int checks_done = 0;
    localparam logic [31:0] TS = 32'h1BCE_6DCE;

    always #4 ref_clk = ~ref_clk;
    initial stat_we = 1'b0;

    bstat_parser #(.DEPTH(32)) u_dut (.ref_clk(ref_clk), .nrst(nrst),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .stat_we(stat_we), .stat_id(stat_id), .stat_val(stat_val),
        .stat_inf(stat_inf), .stat_ts(stat_ts), .soc_level(soc_level),
        .bad_sentence(bad_sentence));
    bstat_host u_host (.ref_clk(ref_clk), .rx_ready(rx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready));

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic chk_str(input string g, input string e);
        int k;
        checks_done++;
        k = 0;
        while (k < g.len() && k < e.len() && g[k] == e[k]) k++;
        if (g != e) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, g[k], e[k]);
        end
    endtask : chk_str

    function automatic string fmt(input logic [31:0] id, v, i, t,
                                  input int nv, ni, nt);
        string b;
        b = {"SS1,", u_host.hx(id, 2), ",", u_host.hx(v, nv), ",",
             u_host.hx(i, ni), ",", u_host.hx(t, nt), ","};
        return {b, u_host.ck(b), "\n"};
    endfunction : fmt

    task automatic wr(input logic [5:0] id, input logic [31:0] v, i, t);
        stat_we <= 1'b1;
        stat_id <= id;
        stat_val <= v;
        stat_inf <= i;
        stat_ts <= t;
        @(posedge ref_clk);
        stat_we <= 1'b0;
        // a free edge keeps the strobe from being raised and dropped at once
        @(posedge ref_clk);
    endtask : wr

    // one line in, then level and error flag just after the end-of-line edge
    task automatic act(input string s, input logic [6:0] soc,
                       input logic bad, input logic good_ck);
        if (good_ck) u_host.cmd(s);
        else u_host.raw(s);
        @(negedge ref_clk);
        chk({1'b0, soc_level}, {1'b0, soc});
        chk({7'h0, bad_sentence}, {7'h0, bad});
        @(posedge ref_clk);
    endtask : act

    task automatic wait_lf(input int n);
        for (int k = 0; k < 20000 && u_host.lfs < n; k++) @(posedge ref_clk);
        repeat (60) @(posedge ref_clk);
        chk(8'(u_host.lfs), 8'(n));
    endtask : wait_lf

    task automatic req(input string body, input string exp);
        u_host.got = "";
        u_host.lfs = 0;
        u_host.cmd(body);
        wait_lf(1);
        chk_str(u_host.got, exp);
    endtask : req

    task automatic t_soc();
        act("SC1,64,", 7'h64, 1'b0, 1'b1);
        act("SC1,0,", 7'h00, 1'b0, 1'b1);
        act("SC1,64,", 7'h64, 1'b0, 1'b1);
        act("SC1,65,", 7'h64, 1'b1, 1'b1);
        act("SC1,32,00\n", 7'h64, 1'b1, 1'b0);
        $display("test soc done");
    endtask : t_soc

    task automatic t_one();
        wr(6'h00, 32'h3, 32'h0, 32'h0);
        wr(6'h07, 32'h0, 32'h12, 32'h0);
        wr(6'h08, 32'h0123, 32'h0, TS);
        wr(6'h0A, 32'h85, 32'h5, TS);
        req("SS1,0A,", fmt(10, 32'h85, 32'h5, TS, 2, 4, 8));
        req("SS1,00,", fmt(0, 32'h3, 0, 0, 8, 0, 0));
        req("SS1,07,", fmt(7, 0, 32'h12, 0, 0, 8, 0));
        req("SS1,08,", fmt(8, 32'h0123, 0, TS, 4, 0, 8));
        act("SS1,1A,", 7'h64, 1'b1, 1'b1);
        $display("test single done");
    endtask : t_one

    task automatic t_clear();
        act("SS1,c,", 7'h64, 1'b0, 1'b1);
        req("SS1,00,", fmt(0, 0, 0, 0, 8, 0, 0));
        req("SS1,07,", fmt(7, 0, 32'h12, 0, 0, 8, 0));
        $display("test clear done");
    endtask : t_clear

    // stored words after the clear: only the protected count survives
    function automatic string all_exp();
        string s;
        int nv, ni, nt;
        bit ok;
        s = "";
        for (int id = 0; id < 50; id++) begin
            ok = (id <= 39 && id != 26) || id == 45 || id == 46 || id == 49;
            nv = id <= 6 ? 8 : id == 7 ? 0 : id <= 9 ? 4 : id <= 11 ? 2 :
                 id <= 17 ? 8 : 0;
            ni = (id <= 6 || id == 8 || id == 9) ? 0 :
                 (id == 10 || id == 11) ? 4 : 8;
            nt = id <= 7 ? 0 : 8;
            if (ok) s = {s, fmt(id, 0, id == 7 ? 32'h12 : 0, 0, nv, ni, nt)};
        end
        return s;
    endfunction : all_exp

    // reader held off so the output buffer fills, then drained at full rate
    task automatic t_all();
        u_host.got = "";
        u_host.lfs = 0;
        u_host.hold <= 1'b1;
        u_host.cmd("SS1,?,");
        repeat (100) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({7'h0, tx_valid}, 8'h01);
        chk({7'h0, rx_ready}, 8'h00);
        u_host.hold <= 1'b0;
        u_host.stall <= 1'b0;
        wait_lf(42);
        chk({7'h0, rx_ready}, 8'h01);
        chk_str(u_host.got, all_exp());
        $display("test all done");
    endtask : t_all

    // reset in mid-run drops the stored level, then a new level is taken
    task automatic t_reset();
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({1'b0, soc_level}, 8'h00);
        chk({7'h0, rx_ready}, 8'h01);
        @(posedge ref_clk);
        act("SC1,32,", 7'h32, 1'b0, 1'b1);
        $display("test reset done");
    endtask : t_reset

    initial begin
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        t_soc();
        t_one();
        t_clear();
        t_all();
        t_reset();
        close_out();
    end

    initial begin
        #400000;
        fails++;
        close_out();
    end
endmodule : test_battery_stats_command_parser
